// >>> design/mccd_device.sv
module mccd_device #(
	parameter logic [15:0] MEM_BASE = 16'h0000, // first address owned
	parameter logic [15:0] MEM_LAST = 16'h03FF, // last address owned
	parameter logic [7:0] PORT_BASE = 8'h04, // first port address owned
	parameter int NUM_PORTS = 2, // readable io ports
	parameter bit HAS_DP2 = 1'b1, // secondary data pointer present
	parameter logic [15:0] VECTOR = 16'h0280 // interrupt vector, arbitrary default
)
(
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic cyc_start, // pulse: cycle begins, cmd valid
	input wire logic [4:0] cmd, // bus_command_code
	input wire logic cyc_end, // pulse: bus byte valid, cycle ends
	input wire logic [7:0] db_in, // resolved data bus level
	output logic [7:0] db_out, // byte this device drives
	output logic db_oe, // high while driving data bus
	output logic [15:0] mem_addr, // program counter to local memory
	input wire logic [7:0] mem_rdata, // memory byte at mem_addr
	input wire logic ext_int, // pulse: external interrupt event
	input wire logic pri_in, // no higher-priority device requests
	output logic int_req, // pending interrupt request
	output logic [NUM_PORTS-1:0][7:0] port_out // io port latches
);
	mccd_pkg::mccd_state_e state_r;
	mccd_pkg::mccd_state_e state_nxt;
	logic [4:0] cmd_r;
	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	logic [15:0] ret_r;
	logic [15:0] ret_nxt;
	logic [15:0] dp_r;
	logic [15:0] dp_nxt;
	logic [15:0] dp2_r;
	logic [15:0] dp2_nxt;
	logic [7:0] last_bus_r;
	logic [7:0] db_out_r;
	logic db_oe_r;
	logic int_pend_r;
	logic vec_mine_r;

	mccd_port_if #(.NUM_PORTS(NUM_PORTS)) pif ();

	mccd_port_regs #(.NUM_PORTS(NUM_PORTS)) u_ports
	(
		.clk(clk),
		.rstn(rstn),
		.pif(pif)
	);

	function automatic logic in_mem(input logic [15:0] a);
		in_mem = (a >= MEM_BASE) && (a <= MEM_LAST);
	endfunction

	// ====================================================
	// cycle tracking
	wire upd = (state_r == mccd_pkg::MCCD_CYC) && cyc_end;
	wire take = (state_r == mccd_pkg::MCCD_IDLE) && cyc_start;
	assign state_nxt = take ? mccd_pkg::MCCD_CYC : (upd ? mccd_pkg::MCCD_IDLE : state_r);

	// ====================================================
	// ownership: previous cycle's bus byte names the port
	// own range compare
	wire pc_own = in_mem(pc_r);
	wire port_hit = (last_bus_r >= PORT_BASE) && ((last_bus_r - PORT_BASE) <= 8'(NUM_PORTS + 1));
	wire vec_sel = int_pend_r && pri_in;

	// ====================================================
	// drive selection, decided at cycle start
	// opcode fetch drive
	wire drv_mem = (cmd == mccd_pkg::CMD_FETCH) && pc_own;
	wire drv_vlo = (cmd == mccd_pkg::CMD_VEC_LO) && vec_sel;
	wire drv_vhi = (cmd == mccd_pkg::CMD_VEC_HI) && vec_sel;
	wire drv_port = (cmd == mccd_pkg::CMD_PORT_RD) && port_hit && pif.readable;
	wire drv_pcl = (cmd == mccd_pkg::CMD_PC_LO_OUT) && pc_own;
	wire drv_pch = (cmd == mccd_pkg::CMD_PC_HI_OUT) && pc_own;
	wire drv_any = drv_mem | drv_vlo | drv_vhi | drv_port | drv_pcl | drv_pch;
	wire [7:0] drv_byte = drv_mem ? mem_rdata :
		drv_vlo ? VECTOR[7:0] :
		drv_vhi ? VECTOR[15:8] :
		drv_port ? pif.rdata :
		drv_pcl ? pc_r[7:0] : pc_r[15:8];

	// ====================================================
	// pointer updates at cycle end; other codes leave all alone
	// every device receives the bus byte
	assign pc_nxt = !upd ? pc_r :
		(cmd_r == mccd_pkg::CMD_FETCH) ? pc_r + mccd_pkg::PC_STEP :
		(cmd_r == mccd_pkg::CMD_VEC_LO || cmd_r == mccd_pkg::CMD_CALL_LO ||
		cmd_r == mccd_pkg::CMD_PC_LO) ? {pc_r[15:8], db_in} :
		(cmd_r == mccd_pkg::CMD_VEC_HI || cmd_r == mccd_pkg::CMD_PC_HI) ? {db_in, pc_r[7:0]} : pc_r;
	assign ret_nxt = !upd ? ret_r :
		(cmd_r == mccd_pkg::CMD_VEC_LO || cmd_r == mccd_pkg::CMD_CALL_LO) ? pc_r :
		(cmd_r == mccd_pkg::CMD_RET_LO_A || cmd_r == mccd_pkg::CMD_RET_LO_B) ? {ret_r[15:8], db_in} : ret_r;
	wire swap = upd && (cmd_r == mccd_pkg::CMD_DP_SWAP) && HAS_DP2;
	assign dp_nxt = swap ? dp2_r :
		(upd && cmd_r == mccd_pkg::CMD_DP_HI) ? {db_in, dp_r[7:0]} :
		(upd && cmd_r == mccd_pkg::CMD_DP_LO) ? {dp_r[15:8], db_in} : dp_r;
	assign dp2_nxt = swap ? dp_r : dp2_r;

	// ====================================================
	// port writes reach the port, timer or control register
	// latch bus into addressed port
	assign pif.wr_en = upd && (cmd_r == mccd_pkg::CMD_PORT_WR) && port_hit;
	assign pif.idx = last_bus_r - PORT_BASE;
	assign pif.wdata = db_in;

	// ====================================================
	// interrupt request: a new event beats the acknowledge clear
	wire int_set = ext_int && pif.intctl_q[mccd_pkg::INT_EN_BIT];
	wire int_clr = upd && (cmd_r == mccd_pkg::CMD_VEC_HI) && vec_mine_r;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= mccd_pkg::MCCD_IDLE;
			cmd_r <= mccd_pkg::CMD_NOP;
			pc_r <= mccd_pkg::RST_PTR;
			ret_r <= mccd_pkg::RST_PTR;
			dp_r <= mccd_pkg::RST_PTR;
			dp2_r <= mccd_pkg::RST_PTR;
			last_bus_r <= mccd_pkg::RST_BYTE;
		end
		else
		begin
			state_r <= state_nxt;
			cmd_r <= take ? cmd : cmd_r;
			pc_r <= pc_nxt;
			ret_r <= ret_nxt;
			dp_r <= dp_nxt;
			dp2_r <= dp2_nxt;
			last_bus_r <= upd ? db_in : last_bus_r;
		end
	end

	// ====================================================
	// bus drive holds from cycle start to cycle end
	// released outside owned cycles, no drive on 0x1C
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			db_oe_r <= 1'b0;
			db_out_r <= mccd_pkg::RST_BYTE;
			vec_mine_r <= 1'b0;
			int_pend_r <= 1'b0;
		end
		else
		begin
			db_oe_r <= take ? drv_any : (upd ? 1'b0 : db_oe_r);
			db_out_r <= (take && drv_any) ? drv_byte : db_out_r;
			vec_mine_r <= take ? drv_vhi : vec_mine_r;
			int_pend_r <= int_set | (int_pend_r & ~int_clr);
		end
	end

	assign db_out = db_out_r;
	assign db_oe = db_oe_r;
	assign mem_addr = pc_r;
	assign int_req = int_pend_r;
	assign port_out = pif.port_q;

	// ====================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_fetch_incr: assert property (upd && cmd_r == mccd_pkg::CMD_FETCH |=> pc_r == $past(pc_r) + 16'h0001)
		else $error("fetch did not step program counter");
	chk_call_save: assert property (upd && cmd_r == mccd_pkg::CMD_CALL_LO |=>
		ret_r == $past(pc_r) && pc_r[7:0] == $past(db_in) && pc_r[15:8] == $past(pc_r[15:8]))
		else $error("call save or low load wrong");
	chk_vec_low: assert property (upd && cmd_r == mccd_pkg::CMD_VEC_LO |=>
		ret_r == $past(pc_r) && pc_r[7:0] == $past(db_in))
		else $error("vector low handling wrong");
	// whole open cycle checked, end cycle included, without an open-ended wait
	chk_vec_drive: assert property (vec_mine_r && state_r == mccd_pkg::MCCD_CYC |-> db_oe && db_out == VECTOR[15:8])
		else $error("vector high not driven through cycle");
	chk_irq_clear: assert property (int_clr && !int_set |=> !int_req)
		else $error("acknowledged request still pending");
	chk_pc_high: assert property (upd && cmd_r == mccd_pkg::CMD_PC_HI |=> pc_r[15:8] == $past(db_in))
		else $error("counter high byte not loaded");
	chk_ret_low: assert property (upd && (cmd_r == mccd_pkg::CMD_RET_LO_A || cmd_r == mccd_pkg::CMD_RET_LO_B)
		|=> ret_r[7:0] == $past(db_in) && ret_r[15:8] == $past(ret_r[15:8]))
		else $error("return low byte not loaded");
	chk_dp_high: assert property (upd && cmd_r == mccd_pkg::CMD_DP_HI |=>
		dp_r == {$past(db_in), $past(dp_r[7:0])})
		else $error("pointer high byte not loaded");
	chk_dp_low: assert property (upd && cmd_r == mccd_pkg::CMD_DP_LO |=>
		dp_r == {$past(dp_r[15:8]), $past(db_in)})
		else $error("pointer low byte not loaded");
	chk_port_write: assert property (pif.wr_en && pif.readable |=>
		port_out[$past(pif.idx[$clog2(NUM_PORTS+1)-1:0])] == $past(db_in))
		else $error("port write lost");
	chk_write_only: assert property (take && cmd == mccd_pkg::CMD_PORT_RD && port_hit && !pif.readable |=> !db_oe)
		else $error("write-only register read back");
	chk_dp_swap: assert property (swap |=> dp_r == $past(dp2_r) && dp2_r == $past(dp_r))
		else $error("pointer swap wrong");
	chk_nop_idle: assert property (upd && cmd_r == mccd_pkg::CMD_NOP |-> !db_oe ##1
		(pc_r == $past(pc_r) && ret_r == $past(ret_r) && dp_r == $past(dp_r)))
		else $error("null command drove bus or moved a pointer");
	chk_pc_out: assert property (take && cmd == mccd_pkg::CMD_PC_LO_OUT && pc_own |=> db_out == $past(pc_r[7:0]))
		else $error("counter low byte not driven");
	chk_bus_release: assert property (db_oe |-> state_r == mccd_pkg::MCCD_CYC)
		else $error("bus driven outside a cycle");
endmodule

// >>> design/mccd_pkg.sv
package mccd_pkg;
	// ====================================================
	// bus command codes handled by this decoder
	localparam logic [4:0] CMD_FETCH = 5'h00;
	localparam logic [4:0] CMD_VEC_LO = 5'h0F;
	localparam logic [4:0] CMD_CALL_LO = 5'h12;
	localparam logic [4:0] CMD_VEC_HI = 5'h13;
	localparam logic [4:0] CMD_PC_HI = 5'h14;
	localparam logic [4:0] CMD_RET_LO_A = 5'h15;
	localparam logic [4:0] CMD_DP_HI = 5'h16;
	localparam logic [4:0] CMD_PC_LO = 5'h17;
	localparam logic [4:0] CMD_RET_LO_B = 5'h18;
	localparam logic [4:0] CMD_DP_LO = 5'h19;
	localparam logic [4:0] CMD_PORT_WR = 5'h1A;
	localparam logic [4:0] CMD_PORT_RD = 5'h1B;
	localparam logic [4:0] CMD_NOP = 5'h1C;
	localparam logic [4:0] CMD_DP_SWAP = 5'h1D;
	localparam logic [4:0] CMD_PC_LO_OUT = 5'h1E;
	localparam logic [4:0] CMD_PC_HI_OUT = 5'h1F;

	// ====================================================
	// values after reset, interrupt enable bit, fetch step
	localparam logic [15:0] RST_PTR = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int INT_EN_BIT = 0;
	localparam logic [15:0] PC_STEP = 16'h0001;

	// ====================================================
	// bus cycle tracking
	typedef enum logic [1:0]
	{
		MCCD_IDLE = 2'b01,
		MCCD_CYC = 2'b10
	} mccd_state_e;
endpackage

// >>> design/mccd_port_if.sv
// port register access between decoder core and port storage
interface mccd_port_if #(parameter int NUM_PORTS = 2);
	logic wr_en;
	logic [7:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic readable;
	logic [NUM_PORTS-1:0][7:0] port_q;
	logic [7:0] timer_q;
	logic [7:0] intctl_q;

	modport core (output wr_en, idx, wdata, input rdata, readable, port_q, timer_q, intctl_q);
	modport regs (input wr_en, idx, wdata, output rdata, readable, port_q, timer_q, intctl_q);
endinterface

// >>> design/mccd_port_regs.sv
// io ports, then timer at NUM_PORTS, interrupt control at NUM_PORTS+1
module mccd_port_regs #(parameter int NUM_PORTS = 2)
(
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, active low
	mccd_port_if.regs pif // access from decoder core
);
	localparam logic [7:0] TIMER_IDX = 8'(NUM_PORTS);
	localparam logic [7:0] INTCTL_IDX = 8'(NUM_PORTS + 1);

	// ====================================================
	// read side: timer and interrupt control never read back
	assign pif.readable = pif.idx < TIMER_IDX;
	assign pif.rdata = pif.readable ? pif.port_q[pif.idx[$clog2(NUM_PORTS+1)-1:0]] : mccd_pkg::RST_BYTE;

	// ====================================================
	// write side
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pif.port_q <= '0;
			pif.timer_q <= mccd_pkg::RST_BYTE;
			pif.intctl_q <= mccd_pkg::RST_BYTE;
		end
		else if (pif.wr_en)
		begin
			if (pif.readable)
				pif.port_q[pif.idx[$clog2(NUM_PORTS+1)-1:0]] <= pif.wdata;
			else if (pif.idx == TIMER_IDX)
				pif.timer_q <= pif.wdata;
			else if (pif.idx == INTCTL_IDX)
				pif.intctl_q <= pif.wdata;
		end
	end
endmodule

// >>> testbench/mccd_cpu_model.sv
// cpu side of the command link: one long bus cycle per call
module mccd_cpu_model
(
	input wire logic clk, // system clock
	input wire logic [7:0] db_in, // resolved data bus
	input wire logic dev_oe, // device drive enable, observed
	output logic cyc_start, // cycle start pulse
	output logic [4:0] cmd, // bus_command_code
	output logic cyc_end, // cycle end pulse
	output logic [7:0] cpu_db, // byte the cpu drives
	output logic cpu_oe // high while cpu drives
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle link at time zero
	initial
	begin
		cyc_start = 1'b0;
		cmd = 5'h00;
		cyc_end = 1'b0;
		cpu_db = 8'h00;
		cpu_oe = 1'b0;
	end
	// cpu off the bus when a device sources
	// command 0x1C closes internal-only work
	// called at a falling edge; returns at one
	task automatic run(input logic [4:0] c, input logic drv, input logic [7:0] v,
		output logic [7:0] seen, output logic seen_oe);
		cyc_start = 1'b1;
		cmd = c;
		cpu_oe = drv;
		cpu_db = v;
		@(negedge clk);
		cyc_start = 1'b0;
		@(negedge clk);
		cyc_end = 1'b1;
		#1;
		seen = db_in;
		seen_oe = dev_oe;
		@(negedge clk);
		cyc_end = 1'b0;
		cpu_oe = 1'b0;
		@(negedge clk);
	endtask
endmodule

// >>> testbench/mccd_tb_top.sv
module mccd_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, cyc_start, cyc_end, cpu_oe, db_oe, int_req, ext_int, pri_in, o;
	logic [4:0] cmd;
	logic [7:0] db_in, db_out, cpu_db, flt, b;
	logic [15:0] mem_addr;
	logic [1:0][7:0] port_out;
	logic [4:0] codes [5] = '{5'h15, 5'h16, 5'h18, 5'h19, 5'h1D};
	int err_total, cmp_count;
	// local memory: byte pattern tied to the address
	wire [7:0] mem_rdata = mem_addr[7:0] ^ 8'h5A;
	// released bus shows a moving pattern, never the last byte
	assign db_in = db_oe ? db_out : (cpu_oe ? cpu_db : flt);
	mccd_device i_mccd_device (.clk(clk), .rstn(rstn), .cyc_start(cyc_start), .cmd(cmd), .cyc_end(cyc_end),
		.db_in(db_in), .db_out(db_out), .db_oe(db_oe), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.ext_int(ext_int), .pri_in(pri_in), .int_req(int_req), .port_out(port_out));
	mccd_cpu_model i_mccd_cpu_model (.clk(clk), .db_in(db_in), .dev_oe(db_oe), .cyc_start(cyc_start),
		.cmd(cmd), .cyc_end(cyc_end), .cpu_db(cpu_db), .cpu_oe(cpu_oe));
	// ====================================================
	// clock and floating-bus pattern
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) flt <= ~flt + 8'h01;
	// ====================================================
	// shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input logic [4:0] c, input logic drv, input logic [7:0] v);
		i_mccd_cpu_model.run(c, drv, v, b, o);
	endtask
	task automatic give_verdict;
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ====================================================
	// scenarios
	task automatic t_fetch;
		cyc(5'h00, 1'b0, 8'h00);
		chk(o, 1, "fetch not driven");
		chk(b, 16'h005A, "fetch byte");
		chk(mem_addr, 16'h0001, "fetch step");
		$display("test fetch done");
	endtask
	task automatic t_pc;
		cyc(5'h14, 1'b1, 8'h01);
		cyc(5'h17, 1'b1, 8'h23);
		chk(mem_addr, 16'h0123, "counter loads");
		cyc(5'h12, 1'b1, 8'h55);
		chk(mem_addr, 16'h0155, "call low load");
		cyc(5'h1E, 1'b0, 8'h00);
		chk(b, 16'h0055, "counter low out");
		cyc(5'h1F, 1'b0, 8'h00);
		chk(b, 16'h0001, "counter high out");
		cyc(5'h1C, 1'b1, 8'h77);
		chk({o, mem_addr}, 16'h0155, "idle code acted");
		foreach (codes[i])
		begin
			cyc(codes[i], 1'b1, 8'h66);
			chk({o, mem_addr}, 16'h0155, "pointer code hit counter");
		end
		chk({i_mccd_device.ret_r, i_mccd_device.dp2_r}, 32'h0166_6666, "pointer loads");
		chk(i_mccd_device.dp_r, 16'h0000, "pointer swap");
		cyc(5'h14, 1'b1, 8'h10);
		cyc(5'h1E, 1'b0, 8'h00);
		chk(o, 0, "foreign range driven");
		cyc(5'h14, 1'b1, 8'h00);
		$display("test counter done");
	endtask
	task automatic t_port;
		cyc(5'h1C, 1'b1, 8'h04);
		cyc(5'h1A, 1'b1, 8'hA5);
		cyc(5'h1C, 1'b1, 8'h05);
		cyc(5'h1A, 1'b1, 8'h3C);
		chk(port_out, 16'h3CA5, "port latches");
		cyc(5'h1C, 1'b1, 8'h04);
		cyc(5'h1B, 1'b0, 8'h00);
		chk({o, b}, 16'h01A5, "port read");
		for (int a = 6; a < 8; a++)
		begin
			cyc(5'h1C, 1'b1, 8'(a));
			cyc(5'h1A, 1'b1, 8'h01);
			cyc(5'h1C, 1'b1, 8'(a));
			cyc(5'h1B, 1'b0, 8'h00);
			chk(o, 0, "write-only read back");
		end
		$display("test port done");
	endtask
	task automatic t_int;
		ext_int = 1'b1;
		@(negedge clk);
		ext_int = 1'b0;
		@(negedge clk);
		chk(int_req, 1, "no request");
		cyc(5'h0F, 1'b0, 8'h00);
		chk(b, 16'h0080, "vector low");
		chk(mem_addr, 16'h0080, "vector low load");
		cyc(5'h13, 1'b0, 8'h00);
		chk(b, 16'h0002, "vector high");
		chk(mem_addr, 16'h0280, "vector high load");
		chk(int_req, 0, "request kept");
		// a higher-priority device holds the bus: stay off it, keep the request
		ext_int = 1'b1;
		@(negedge clk);
		ext_int = 1'b0;
		pri_in = 1'b0;
		cyc(5'h13, 1'b1, 8'h02);
		chk({o, int_req}, 1, "lower priority answered");
		pri_in = 1'b1;
		$display("test interrupt done");
	endtask
	// ====================================================
	// main sequence and hang guard
	initial
	begin
		rstn = 1'b0;
		ext_int = 1'b0;
		pri_in = 1'b1;
		flt = 8'hC3;
		repeat (20) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		chk({int_req, db_oe, mem_addr}, 16'h0000, "reset state");
		t_fetch();
		t_pc();
		t_port();
		t_int();
		give_verdict();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		give_verdict();
	end
endmodule
